// File: shared/nv_sram_defines.vh
// Constants of the nonvolatile SRAM two-wire front end and store controller
`ifndef NV_SRAM_DEFINES_VH
`define NV_SRAM_DEFINES_VH

// Clock and timing figures in nanoseconds, and the timer width in bits
`define CLK_PERIOD_NS          10
`define STORE_CYCLE_NS         8000000
`define STORE_REQUEST_DELAY_NS 1000
`define POST_STORE_HOLDOFF_NS  20000
`define POWER_UP_RECALL_NS     20000000
`define TMR_W                  32

// Memory array and slave identifiers (identifier values are arbitrary)
`define MEM_AW                 17
`define MEM_ID                 6'h28
`define RTC_ID                 7'h68
`define CTL_ID                 7'h18
`define DEV_ID_DEFAULT         32'h0000_0000

// Register spaces
`define RTC_LAST               8'h0F
`define CTL_MEMCTL             8'h00
`define CTL_SN_FIRST           8'h01
`define CTL_SN_LAST            8'h08
`define CTL_ID_FIRST           8'h09
`define CTL_LAST               8'h0C
`define CTL_CMD                8'hAA

// Memory control register fields
`define BP_LSB                 2
`define BP_MSB                 3
`define LOCK_BIT               6
`define BP_NONE                2'b00
`define BP_QUARTER             2'b01
`define BP_HALF                2'b10
`define QUARTER_BASE           17'h18000
`define HALF_BASE              17'h10000

// Command register opcodes
`define CMD_STORE              8'h3C
`define CMD_RECALL             8'h60
`define CMD_AS_EN              8'h59
`define CMD_AS_DIS             8'h19

// Bit phase of a byte on the bus
`define BYTE_BITS              4'h8
`define ACK_PHASE              4'h9

// Synchroniser lanes and their reset levels
`define SYNC_N                 5
`define SY_SCL                 0
`define SY_SDA                 1
`define SY_WP                  2
`define SY_HSB                 3
`define SY_SUP                 4
`define SYNC_RST               5'h0B

`endif

// File: core/nv_sram_array.v
// Byte-wide single-port SRAM array with registered read data
module nv_sram_array #(
  parameter DW = 8,
  parameter AW = 17
) (
  input  wire          clk_i,
  input  wire          we_i,
  input  wire [AW-1:0] addr_i,
  input  wire [DW-1:0] wdata_i,
  output reg  [DW-1:0] rdata_o
);

  reg [DW-1:0] mem_q [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem_q[addr_i] <= wdata_i;
    end
    rdata_o <= mem_q[addr_i];
  end

endmodule

// File: core/nv_sram_i2c_access_store_ctrl.v
// Two-wire slave front end of a nonvolatile SRAM with store and recall control
// Operation
// - Write-protect input high blocks every write
// - Protected writes discarded, counter not incremented
// - Supply loss blocks access, starts capacitor store
// - Power-loss store skipped when nothing written
// - Store pin low starts store after delay
// - Hardware store runs only if SRAM written
// - Access refused for store time or pin low
// - Store pin pulled low while storing
// - Access held off after store/recall once pin returns high
// - Power-up recall blocks access for recall time
// - Address byte bit zero selects read/write
// - Unknown device identifier gets not-acknowledge
// - Protected block write nacked, counter holds there
// - Nonexistent address nacked after address byte
// - After nack ignore data until stop/start
// - Read-only register write nacked, counter stays
// - Byte committed right after eighth bit
// - Read follows last access and wraps
// - Control reads past end wrap to zero
// - Memory burst writes increment, wrap, acknowledge
// - Block-protect field selects protected range
`include "nv_sram_defines.vh"
module nv_sram_i2c_access_store_ctrl #(
  parameter [`TMR_W-1:0] STORE_CYC  = (`STORE_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter [`TMR_W-1:0] DELAY_CYC  =
    (`STORE_REQUEST_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter [`TMR_W-1:0] HOLD_CYC   =
    (`POST_STORE_HOLDOFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter [`TMR_W-1:0] RECALL_CYC =
    (`POWER_UP_RECALL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter [31:0]       DEV_ID     = `DEV_ID_DEFAULT
) (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  input  wire       write_protect_i,
  input  wire       supply_ok_i,
  input  wire       hardware_store_busy_pin_i,
  output reg        hardware_store_busy_pin_o,
  output reg        hardware_store_busy_pin_oe_o,
  output reg        access_blocked_o,
  output reg  [1:0] block_protect_field_o,
  output reg        nv_dirty_o
);

  localparam [2:0] S_IDLE = 3'd0, S_DEV = 3'd1, S_AHI = 3'd2, S_ALO = 3'd3,
                   S_WDAT = 3'd4, S_RDAT = 3'd5, S_IGN = 3'd6;
  localparam [1:0] SP_MEM = 2'd0, SP_RTC = 2'd1, SP_CTL = 2'd2;
  localparam [2:0] NV_OFF = 3'd0, NV_RECALL = 3'd1, NV_READY = 3'd2, NV_WAIT = 3'd3,
                   NV_STORE = 3'd4, NV_HOLD = 3'd5;

  function [7:0] wrap_next;
    input [7:0] a;
    input [7:0] last;
    begin
      wrap_next = (a >= last) ? 8'h00 : a + 8'h01;
    end
  endfunction

  function bp_hit;
    input [`MEM_AW-1:0] a;
    input [1:0]         bp;
    begin
      case (bp)
        `BP_NONE:    bp_hit = 1'b0;
        `BP_QUARTER: bp_hit = (a >= `QUARTER_BASE);
        `BP_HALF:    bp_hit = (a >= `HALF_BASE);
        default:     bp_hit = 1'b1;
      endcase
    end
  endfunction

  // Two-flop synchronisers for every pin input
  wire [`SYNC_N-1:0] raw = {supply_ok_i, hardware_store_busy_pin_i, write_protect_i,
                            sda_i, scl_i};
  localparam [`SYNC_N-1:0] SYNC_RST_V = `SYNC_RST;
  reg  [`SYNC_N-1:0] sync1_q;
  reg  [`SYNC_N-1:0] sync2_q;
  genvar g;
  generate
    for (g = 0; g < `SYNC_N; g = g + 1) begin : g_sync
      always @(posedge clk_i) begin
        if (rst_i) begin
          sync1_q[g] <= SYNC_RST_V[g];
          sync2_q[g] <= SYNC_RST_V[g];
        end else begin
          sync1_q[g] <= raw[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  wire scl = sync2_q[`SY_SCL];
  wire sda = sync2_q[`SY_SDA];
  wire wp  = sync2_q[`SY_WP];
  wire hardware_store_busy_pin = sync2_q[`SY_HSB];
  wire sup = sync2_q[`SY_SUP];

  reg  scl_p_q;
  reg  sda_p_q;
  wire scl_rise = scl & ~scl_p_q;
  wire scl_fall = ~scl & scl_p_q;
  wire bus_start = scl & scl_p_q & sda_p_q & ~sda;
  wire bus_stop  = scl & scl_p_q & ~sda_p_q & sda;

  reg [2:0]         state_q;
  reg [3:0]         cnt_q;
  reg [7:0]         sh_q;
  reg [7:0]         tx_q;
  reg [1:0]         space_q;
  reg               a16_q;
  reg [7:0]         ahi_q;
  reg               nack_seen_q;
  reg [`MEM_AW-1:0] mem_cnt_q;
  reg [7:0]         rtc_cnt_q;
  reg [7:0]         ctl_cnt_q;
  reg [7:0]         rtc_q [0:`RTC_LAST];
  reg [7:0]         sn_q [`CTL_SN_FIRST:`CTL_SN_LAST];
  reg [1:0]         bp_q;
  reg               lock_q;
  reg               as_en_q;
  reg               sw_store_q;
  reg               sw_recall_q;
  reg               mem_we_q;
  reg [`MEM_AW-1:0] mem_wa_q;
  reg [7:0]         mem_wd_q;
  wire [7:0]        mem_rd;
  reg [2:0]         nv_q;
  reg [2:0]         nv_d;
  reg [`TMR_W-1:0]  tmr_q;
  reg [`TMR_W-1:0]  tmr_d;
  reg               dirty_q;
  reg               clr_dirty;
  integer           i;

  nv_sram_array #(
    .DW (8),
    .AW (`MEM_AW)
  ) u_array (
    .clk_i   (clk_i),
    .we_i    (mem_we_q),
    .addr_i  (mem_we_q ? mem_wa_q : mem_cnt_q),
    .wdata_i (mem_wd_q),
    .rdata_o (mem_rd)
  );

  // Read address of each register space, wrapped when past the end
  wire [7:0] rtc_ra = (rtc_cnt_q > `RTC_LAST) ? 8'h00 : rtc_cnt_q;
  wire [7:0] ctl_ra = (ctl_cnt_q > `CTL_LAST) ? 8'h00 : ctl_cnt_q;

  reg [7:0] ctl_rd;
  always @* begin
    ctl_rd = 8'h00;
    if (ctl_ra == `CTL_MEMCTL) begin
      ctl_rd[`LOCK_BIT] = lock_q;
      ctl_rd[`BP_MSB:`BP_LSB] = bp_q;
    end else if (ctl_ra <= `CTL_SN_LAST) begin
      ctl_rd = sn_q[ctl_ra];
    end else begin
      ctl_rd = DEV_ID[(`CTL_LAST - ctl_ra) * 8 +: 8];
    end
  end

  wire [7:0] rd_byte = (space_q == SP_MEM) ? mem_rd :
                       (space_q == SP_RTC) ? rtc_q[rtc_ra[3:0]] : ctl_rd;

  // Refusal of a data byte, decided once its eighth bit is in
  wire ctl_ro = (ctl_cnt_q >= `CTL_ID_FIRST && ctl_cnt_q <= `CTL_LAST) ||
                (lock_q && ctl_cnt_q >= `CTL_SN_FIRST && ctl_cnt_q <= `CTL_SN_LAST);
  wire wr_refuse = wp | access_blocked_o |
                   ((space_q == SP_MEM) && bp_hit(mem_cnt_q, bp_q)) |
                   ((space_q == SP_CTL) && ctl_ro);

  always @(posedge clk_i) begin
    if (rst_i) begin
      scl_p_q     <= 1'b1;
      sda_p_q     <= 1'b1;
      state_q     <= S_IDLE;
      cnt_q       <= 4'h0;
      sh_q        <= 8'h00;
      tx_q        <= 8'h00;
      space_q     <= SP_MEM;
      a16_q       <= 1'b0;
      ahi_q       <= 8'h00;
      nack_seen_q <= 1'b0;
      mem_cnt_q   <= {`MEM_AW{1'b0}};
      rtc_cnt_q   <= 8'h00;
      ctl_cnt_q   <= 8'h00;
      bp_q        <= `BP_NONE;
      lock_q      <= 1'b0;
      as_en_q     <= 1'b1;
      sw_store_q  <= 1'b0;
      sw_recall_q <= 1'b0;
      mem_we_q    <= 1'b0;
      mem_wa_q    <= {`MEM_AW{1'b0}};
      mem_wd_q    <= 8'h00;
      sda_oe_o    <= 1'b0;
      sda_o       <= 1'b0;
      for (i = 0; i <= `RTC_LAST; i = i + 1) begin
        rtc_q[i] <= 8'h00;
      end
      for (i = `CTL_SN_FIRST; i <= `CTL_SN_LAST; i = i + 1) begin
        sn_q[i] <= 8'h00;
      end
    end else begin
      scl_p_q     <= scl;
      sda_p_q     <= sda;
      sda_o       <= 1'b0;
      mem_we_q    <= 1'b0;
      sw_store_q  <= 1'b0;
      sw_recall_q <= 1'b0;
      if (bus_start) begin
        state_q  <= S_DEV;
        cnt_q    <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        state_q  <= S_IDLE;
        cnt_q    <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (state_q != S_IDLE && scl_rise) begin
        if (cnt_q < `BYTE_BITS) begin
          sh_q <= {sh_q[6:0], sda};
        end else if (state_q == S_RDAT) begin
          nack_seen_q <= sda;
        end
        cnt_q <= cnt_q + 4'h1;
      end else if (state_q != S_IDLE && scl_fall) begin
        if (cnt_q == `BYTE_BITS) begin
          sda_oe_o <= 1'b0;
          case (state_q)
            S_DEV: begin
              nack_seen_q <= 1'b0;
              if (access_blocked_o) begin
                state_q <= S_IGN;
              end else if (sh_q[7:2] == `MEM_ID) begin
                space_q  <= SP_MEM;
                a16_q    <= sh_q[1];
                sda_oe_o <= 1'b1;
                state_q  <= sh_q[0] ? S_RDAT : S_AHI;
              end else if (sh_q[7:1] == `RTC_ID || sh_q[7:1] == `CTL_ID) begin
                space_q  <= (sh_q[7:1] == `RTC_ID) ? SP_RTC : SP_CTL;
                sda_oe_o <= 1'b1;
                state_q  <= sh_q[0] ? S_RDAT : S_ALO;
              end else begin
                state_q <= S_IGN;
              end
            end
            S_AHI: begin
              ahi_q    <= sh_q;
              sda_oe_o <= 1'b1;
              state_q  <= S_ALO;
            end
            S_ALO: begin
              if (space_q == SP_MEM) begin
                mem_cnt_q <= {a16_q, ahi_q, sh_q};
                sda_oe_o  <= 1'b1;
                state_q   <= S_WDAT;
              end else if (space_q == SP_RTC && sh_q <= `RTC_LAST) begin
                rtc_cnt_q <= sh_q;
                sda_oe_o  <= 1'b1;
                state_q   <= S_WDAT;
              end else if (space_q == SP_CTL && (sh_q <= `CTL_LAST || sh_q == `CTL_CMD)) begin
                ctl_cnt_q <= sh_q;
                sda_oe_o  <= 1'b1;
                state_q   <= S_WDAT;
              end else begin
                state_q <= S_IGN;
              end
            end
            S_WDAT: begin
              if (wr_refuse) begin
                state_q <= S_IGN;
              end else begin
                sda_oe_o <= 1'b1;
                if (space_q == SP_MEM) begin
                  mem_we_q  <= 1'b1;
                  mem_wa_q  <= mem_cnt_q;
                  mem_wd_q  <= sh_q;
                  mem_cnt_q <= mem_cnt_q + {{(`MEM_AW-1){1'b0}}, 1'b1};
                end else if (space_q == SP_RTC) begin
                  rtc_q[rtc_cnt_q[3:0]] <= sh_q;
                  rtc_cnt_q <= wrap_next(rtc_cnt_q, `RTC_LAST);
                end else if (ctl_cnt_q == `CTL_CMD) begin
                  sw_store_q  <= (sh_q == `CMD_STORE);
                  sw_recall_q <= (sh_q == `CMD_RECALL);
                  if (sh_q == `CMD_AS_EN) begin
                    as_en_q <= 1'b1;
                  end else if (sh_q == `CMD_AS_DIS) begin
                    as_en_q <= 1'b0;
                  end
                end else begin
                  if (ctl_cnt_q == `CTL_MEMCTL) begin
                    bp_q   <= sh_q[`BP_MSB:`BP_LSB];
                    lock_q <= lock_q | sh_q[`LOCK_BIT];
                  end else begin
                    sn_q[ctl_cnt_q] <= sh_q;
                  end
                  ctl_cnt_q <= wrap_next(ctl_cnt_q, `CTL_LAST);
                end
              end
            end
            default: begin
            end
          endcase
        end else if (cnt_q == `ACK_PHASE) begin
          cnt_q    <= 4'h0;
          sda_oe_o <= 1'b0;
          if (state_q == S_RDAT) begin
            if (nack_seen_q) begin
              state_q <= S_IGN;
            end else begin
              tx_q     <= rd_byte;
              sda_oe_o <= ~rd_byte[7];
              if (space_q == SP_MEM) begin
                mem_cnt_q <= mem_cnt_q + {{(`MEM_AW-1){1'b0}}, 1'b1};
              end else if (space_q == SP_RTC) begin
                rtc_cnt_q <= wrap_next(rtc_ra, `RTC_LAST);
              end else begin
                ctl_cnt_q <= wrap_next(ctl_ra, `CTL_LAST);
              end
            end
          end
        end else if (state_q == S_RDAT && cnt_q != 4'h0) begin
          tx_q     <= {tx_q[6:0], 1'b0};
          sda_oe_o <= ~tx_q[6];
        end
      end
    end
  end

  // Store and recall sequencing
  always @* begin
    nv_d      = nv_q;
    tmr_d     = (tmr_q == {`TMR_W{1'b0}}) ? tmr_q : tmr_q - {{(`TMR_W-1){1'b0}}, 1'b1};
    clr_dirty = 1'b0;
    case (nv_q)
      NV_OFF: begin
        if (sup) begin
          nv_d      = NV_RECALL;
          tmr_d     = RECALL_CYC - 1;
          clr_dirty = 1'b1;
        end
      end
      NV_RECALL: begin
        // Holdoff until the own busy drive has left the synchronised pin
        if (tmr_q == {`TMR_W{1'b0}}) begin
          nv_d  = NV_HOLD;
          tmr_d = HOLD_CYC - 1;
        end
      end
      NV_READY: begin
        if (sw_store_q) begin
          nv_d      = NV_STORE;
          tmr_d     = STORE_CYC - 1;
          clr_dirty = 1'b1;
        end else if (sw_recall_q) begin
          nv_d      = NV_RECALL;
          tmr_d     = RECALL_CYC - 1;
          clr_dirty = 1'b1;
        end else if (!hardware_store_busy_pin) begin
          nv_d  = NV_WAIT;
          tmr_d = DELAY_CYC - 1;
        end
      end
      NV_WAIT: begin
        if (tmr_q == {`TMR_W{1'b0}}) begin
          if (dirty_q) begin
            nv_d      = NV_STORE;
            tmr_d     = STORE_CYC - 1;
            clr_dirty = 1'b1;
          end else if (hardware_store_busy_pin) begin
            nv_d = NV_READY;
          end
        end
      end
      NV_STORE: begin
        if (tmr_q == {`TMR_W{1'b0}}) begin
          nv_d  = sup ? NV_HOLD : NV_OFF;
          tmr_d = HOLD_CYC - 1;
        end
      end
      NV_HOLD: begin
        if (!hardware_store_busy_pin) begin
          tmr_d = HOLD_CYC - 1;
        end else if (tmr_q == {`TMR_W{1'b0}}) begin
          nv_d = NV_READY;
        end
      end
      default: begin
        nv_d = NV_OFF;
      end
    endcase
    if (!sup && nv_q != NV_OFF && nv_q != NV_STORE) begin
      if (dirty_q && as_en_q && nv_q != NV_RECALL) begin
        nv_d      = NV_STORE;
        tmr_d     = STORE_CYC - 1;
        clr_dirty = 1'b1;
      end else begin
        nv_d = NV_OFF;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      nv_q                         <= NV_OFF;
      tmr_q                        <= {`TMR_W{1'b0}};
      dirty_q                      <= 1'b0;
      access_blocked_o             <= 1'b1;
      hardware_store_busy_pin_o    <= 1'b0;
      hardware_store_busy_pin_oe_o <= 1'b0;
      block_protect_field_o        <= `BP_NONE;
      nv_dirty_o                   <= 1'b0;
    end else begin
      nv_q                         <= nv_d;
      tmr_q                        <= tmr_d;
      dirty_q                      <= (dirty_q & ~clr_dirty) | mem_we_q;
      access_blocked_o             <= (nv_d != NV_READY);
      hardware_store_busy_pin_o    <= 1'b0;
      hardware_store_busy_pin_oe_o <= (nv_d == NV_STORE) || (nv_d == NV_RECALL);
      block_protect_field_o        <= bp_q;
      nv_dirty_o                   <= (dirty_q & ~clr_dirty) | mem_we_q;
    end
  end

endmodule

// File: dv/nv_sram_ctrl_sva.sv
// Concurrent checks on the ports of the nonvolatile SRAM front end
module nv_sram_ctrl_sva #(
  parameter int DELAY_CYC = 5,
  parameter int STORE_CYC = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic write_protect_i,
  input wire logic supply_ok_i,
  input wire logic hardware_store_busy_pin_i,
  input wire logic sda_oe_o,
  input wire logic hardware_store_busy_pin_oe_o,
  input wire logic access_blocked_o,
  input wire logic nv_dirty_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic       st_q;
  logic [7:0] lo_q;
  logic [7:0] on_q;
  // Cycles of outside store request, cycles of busy drive, and whether that store was dirty
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= 1'b0;
      lo_q <= 8'h00;
      on_q <= 8'h00;
    end else begin
      lo_q <= (!hardware_store_busy_pin_i && !hardware_store_busy_pin_oe_o) ?
              ((lo_q == 8'hFF) ? lo_q : lo_q + 8'h01) : 8'h00;
      on_q <= hardware_store_busy_pin_oe_o ? ((on_q == 8'hFF) ? on_q : on_q + 8'h01) : 8'h00;
      if (hardware_store_busy_pin_oe_o && on_q == 8'h00) begin
        st_q <= $past(nv_dirty_o);
      end
    end
  end

  sequence s_wp_held;
    write_protect_i [*5];
  endsequence
  sequence s_up;
    !supply_ok_i ##1 supply_ok_i;
  endsequence
  sequence s_store_end;
    $fell(hardware_store_busy_pin_oe_o) && st_q && supply_ok_i;
  endsequence

  property p_ack_edge;
    $changed(sda_oe_o) |-> !scl_i;
  endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("data line changed with bus clock high");
  property p_wp_hold;
    s_wp_held ##0 !nv_dirty_o |=> !nv_dirty_o;
  endproperty
  a_wp_hold: assert property (p_wp_hold) else $error("write landed under write protect");
  property p_quiet;
    access_blocked_o [*8] |-> !$rose(sda_oe_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus answered while blocked");
  property p_dirty_clr;
    $fell(nv_dirty_o) |-> hardware_store_busy_pin_oe_o || $past(hardware_store_busy_pin_oe_o);
  endproperty
  a_dirty_clr: assert property (p_dirty_clr) else $error("dirty cleared with no store");
  property p_up;
    s_up |-> ##[1:8] hardware_store_busy_pin_oe_o;
  endproperty
  a_up: assert property (p_up) else $error("no recall at supply rise");
  property p_down;
    $fell(supply_ok_i) |-> ##[0:6] access_blocked_o;
  endproperty
  a_down: assert property (p_down) else $error("access not blocked at supply loss");
  property p_delay;
    $rose(hardware_store_busy_pin_oe_o) && supply_ok_i && $past(nv_dirty_o) &&
      $past(!hardware_store_busy_pin_i) |-> lo_q >= DELAY_CYC;
  endproperty
  a_delay: assert property (p_delay) else $error("store began before request delay");
  property p_len;
    s_store_end |-> on_q >= STORE_CYC;
  endproperty
  a_len: assert property (p_len) else $error("store shorter than store cycle");
  property p_hold;
    s_store_end |-> access_blocked_o [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("no holdoff after store");
endmodule

// File: dv/i2c_master_model.sv
// Behavioural two-wire bus master; the bus clock idles high between frames
module i2c_master_model (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Data moves two cycles after the clock falls so it never races the clock edge
  task automatic low_then(input logic v);
    repeat (2) @(posedge clk_i);
    sda_low_o <= v;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic start();
    low_then(1'b0);
    scl_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    sda_low_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    low_then(1'b1);
    scl_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    sda_low_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic bit_io(input logic b, output logic r);
    low_then(!b);
    scl_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    r = sda_i;
    scl_o <= 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r); // Direction in bit zero
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r); // Released on the last byte, then stop
  endtask
endmodule

// File: dv/nv_sram_i2c_access_store_ctrl_tb_top.sv
// Self-checking bench for the nonvolatile SRAM two-wire front end
module nv_sram_i2c_access_store_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STORE_CYC = 20;
  localparam int DELAY_CYC = 5;
  localparam int HOLD_CYC = 10;
  localparam int RECALL_CYC = 30;
  localparam logic [16:0] AD [4] = '{17'h0FFFF, 17'h10000, 17'h17FFF, 17'h18000};
  typedef logic [7:0] bq_t[$];
  logic       clk_i, rst_i, scl, sda_low, sda_oe, sda_o, wp, sup, hsb_req, hsb_o, hsb_oe;
  logic       blk, dirty;
  logic [1:0] bpf;
  int         mismatches, cmp_count;
  wire logic  sda = !(sda_low | sda_oe);
  wire logic  hardware_store_busy_pin = !(hsb_req | hsb_oe);

  nv_sram_i2c_access_store_ctrl #(
    .STORE_CYC(STORE_CYC), .DELAY_CYC(DELAY_CYC), .HOLD_CYC(HOLD_CYC), .RECALL_CYC(RECALL_CYC)
  ) dut (
    .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .write_protect_i(wp), .supply_ok_i(sup), .hardware_store_busy_pin_i(hardware_store_busy_pin),
    .hardware_store_busy_pin_o(hsb_o), .hardware_store_busy_pin_oe_o(hsb_oe),
    .access_blocked_o(blk), .block_protect_field_o(bpf), .nv_dirty_o(dirty)
  );
  i2c_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // Bounded wait on blocked (0), busy drive (1); sampled on the falling edge
  task automatic wait_on(input int w, input logic v, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      if ((w == 0 ? blk : hsb_oe) === v) begin
        @(posedge clk_i);
        return;
      end
    end
    mismatches++;
    $display("Error wait %0d expected %0h seen timeout", w, v);
    finish_test();
  endtask
  task automatic wseq(input bq_t bs, input logic fin, output logic [7:0] ak);
    logic a;
    ak = 8'h00;
    m.start();
    foreach (bs[i]) begin
      m.wr_byte(bs[i], a);
      ak[i] = a;
    end
    if (fin) m.stop();
  endtask
  task automatic rdn(input logic [7:0] dev, input int n, output logic [15:0] d);
    logic       a;
    logic [7:0] b;
    d = 16'h0000;
    m.start();
    m.wr_byte(dev, a);
    chk("read ack", a, 1'b1);
    for (int i = 0; i < n; i++) begin
      m.rd_byte(i == n - 1, b);
      d = {d[7:0], b};
    end
    m.stop();
  endtask

  task automatic t_mem();
    logic [7:0]  ak;
    logic [15:0] d;
    wait_on(1, 1'b1, 10);
    wait_on(0, 1'b0, RECALL_CYC + 20);
    chk("dirty", dirty, 1'b0);
    wseq('{8'hA2, 8'hFF, 8'hFF, 8'h11, 8'h22}, 1, ak);
    chk("burst acks", ak, 8'h1F);
    chk("dirty", dirty, 1'b1);
    wseq('{8'hA2, 8'hFF, 8'hFF}, 0, ak);
    rdn(8'hA3, 2, d);
    chk("wrap read", d, 16'h1122);
    wseq('{8'h40}, 1, ak);
    chk("bad id", ak, 8'h00);
    wp <= 1'b1;
    repeat (5) @(posedge clk_i);
    wseq('{8'hA0, 8'h00, 8'h00, 8'h77, 8'h88}, 1, ak);
    chk("wp acks", ak, 8'h07);
    wp <= 1'b0;
    repeat (5) @(posedge clk_i);
    rdn(8'hA1, 1, d);
    chk("wp data", d, 16'h0022);
    $display("Test memory done");
  endtask
  task automatic t_regs();
    logic [7:0]  ak;
    logic [15:0] d;
    wseq('{8'hD0, 8'h0E, 8'hC3, 8'hA5, 8'h5B}, 1, ak);
    chk("rtc acks", ak, 8'h1F);
    wseq('{8'hD0, 8'h0E}, 0, ak);
    rdn(8'hD1, 1, d);
    chk("rtc read", d, 16'h00C3);
    wseq('{8'hD0, 8'h3F}, 1, ak);
    chk("rtc range", ak, 8'h01);
    wseq('{8'h30, 8'h0D}, 1, ak);
    chk("ctl range", ak, 8'h01);
    rdn(8'hD1, 2, d);
    chk("rtc wrap", d, 16'hA55B);
    wseq('{8'h30, 8'h00, 8'h08}, 1, ak);
    wseq('{8'h30, 8'h0C, 8'h66}, 1, ak);
    chk("ro acks", ak, 8'h03);
    rdn(8'h31, 2, d);
    chk("ro read", d, 16'h0008);
    for (int c = 0; c < 2; c++) begin
      wseq('{8'h30, 8'hAA, c ? 8'h60 : 8'h3C}, 0, ak);
      wait_on(1, 1'b1, 5);
      chk("cmd acks", ak, 8'h07);
      m.stop();
      wait_on(0, 1'b0, RECALL_CYC + HOLD_CYC);
    end
    $display("Test registers done");
  endtask
  task automatic t_bp();
    logic [7:0]  ak;
    logic [16:0] a;
    logic [1:0]  bp;
    logic        p;
    for (int i = 0; i < 4; i++) begin
      bp = 2'(3 - i);
      wseq('{8'h30, 8'h00, {4'h0, bp, 2'b00}}, 1, ak);
      chk("bp field", bpf, bp);
      for (int j = 0; j < 4; j++) begin
        a = AD[j];
        p = bp == 2'b11 || (bp == 2'b10 && a[16]) || (bp == 2'b01 && a[16:15] == 2'b11);
        wseq('{{6'h28, a[16], 1'b0}, a[15:8], a[7:0], 8'h3C}, 1, ak);
        chk("protect ack", ak, p ? 8'h07 : 8'h0F);
      end
    end
    $display("Test protect done");
  endtask
  task automatic t_store();
    logic [7:0] ak;
    hsb_req <= 1'b1; // Requested while idle, after the last data bit
    wait_on(1, 1'b1, DELAY_CYC + 15);
    chk("store blocked", blk, 1'b1);
    chk("busy level", {hsb_o, sda_o}, 2'b00);
    hsb_req <= 1'b0;
    wait_on(1, 1'b0, STORE_CYC + 15);
    chk("store dirty", dirty, 1'b0);
    wait_on(0, 1'b0, HOLD_CYC + 15);
    hsb_req <= 1'b1;
    repeat (DELAY_CYC + 15) @(posedge clk_i);
    chk("clean store", hsb_oe, 1'b0);
    hsb_req <= 1'b0;
    wait_on(0, 1'b0, HOLD_CYC + 15);
    wp <= 1'b1;
    repeat (5) @(posedge clk_i);
    wseq('{8'hA0, 8'h00, 8'h05, 8'h99}, 1, ak);
    chk("wp clean", {ak, dirty}, 9'h00E);
    wp <= 1'b0;
    repeat (5) @(posedge clk_i);
    wseq('{8'hA0, 8'h00, 8'h05, 8'h99}, 1, ak);
    sup <= 1'b0;
    wait_on(1, 1'b1, 15);
    chk("loss blocked", blk, 1'b1);
    wait_on(1, 1'b0, STORE_CYC + 15);
    sup <= 1'b1;
    wait_on(1, 1'b1, 15);
    wait_on(0, 1'b0, RECALL_CYC + 20);
    chk("recall dirty", dirty, 1'b0);
    sup <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("clean loss", hsb_oe, 1'b0);
    sup <= 1'b1;
    wait_on(0, 1'b0, RECALL_CYC + 30);
    $display("Test store done");
  endtask

  initial begin
    rst_i = 1'b1;
    wp = 1'b0;
    sup = 1'b1;
    hsb_req = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_mem();
    t_regs();
    t_bp();
    t_store();
    finish_test();
  end
endmodule

bind nv_sram_i2c_access_store_ctrl nv_sram_ctrl_sva #(
  .DELAY_CYC(DELAY_CYC), .STORE_CYC(STORE_CYC)
) u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .write_protect_i(write_protect_i),
  .supply_ok_i(supply_ok_i), .hardware_store_busy_pin_i(hardware_store_busy_pin_i),
  .sda_oe_o(sda_oe_o), .hardware_store_busy_pin_oe_o(hardware_store_busy_pin_oe_o),
  .access_blocked_o(access_blocked_o), .nv_dirty_o(nv_dirty_o)
);
